// >>> logic/avm_matcher.sv
// Functional notes
// - Tag mode: any, tagged only, untagged only
// - VLAN ID don't-care ignores frame VLAN ID
// - Specific VLAN ID must equal configured value
// - Tag priority equals value, or don't-care
// - ARP criteria apply only for ARP entries
// - Opcode kind: any, ARP, RARP, other
// - Request/reply: any, request, reply
// - Sender IP: any, host, masked network
// - Target IP: any, host, masked network
// - Sender hardware address versus source MAC
// - Target hardware address versus source MAC
// - Lengths 0x06 and 0x04 match or mismatch
// - Hardware type equals 1, or not
// - Protocol type equals 0x800, or not
// - Deny entry drops every hitting frame
// - Hit counter increments once per hit
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "avm_map.svh"
module avm_matcher
#(
   parameter int CNT_W = 32,
   parameter int ADDR_W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frm_valid,
   input wire avm_pkg::avm_ftype_t frm_kind,
   input wire logic frm_tagged,
   input wire logic [11:0] frm_vid,
   input wire logic [2:0] frm_pcp,
   input wire logic [47:0] frame_source_mac,
   input wire logic [15:0] arp_opcode,
   input wire logic [47:0] arp_sha,
   input wire logic [47:0] arp_tha,
   input wire logic [31:0] arp_spa,
   input wire logic [31:0] arp_tpa,
   input wire logic [7:0] arp_hln,
   input wire logic [7:0] arp_pln,
   input wire logic [15:0] arp_hrd,
   input wire logic [15:0] arp_pro,
   output logic res_valid,
   output logic res_hit,
   output logic res_drop,
   output logic irq
);
   import avm_pkg::*;

   typedef struct packed {
      avm_ftype_t ftype;
      logic deny;
      avm_tag_t tag;
      logic vid_spec;
      logic pcp_spec;
      logic [2:0] pcp;
      logic [11:0] vid;
      avm_opk_t opk;
      avm_rr_t rr;
      avm_ipm_t sipm;
      avm_ipm_t tipm;
      avm_chk_t sha;
      avm_chk_t tha;
      avm_chk_t len;
      avm_chk_t hrd;
      avm_chk_t pro;
      logic [31:0] sip;
      logic [31:0] sipmsk;
      logic [31:0] tip;
      logic [31:0] tipmsk;
      logic [CNT_W-1:0] count;
      logic [2:0] irq_st;
      logic [2:0] irq_en;
      logic [31:0] rdata;
      logic res_valid;
      logic hit;
      logic drop;
   } avm_state_t;

   avm_state_t st;
   avm_state_t next_st;
   logic type_ok;
   logic tag_ok;
   logic vid_ok;
   logic pcp_ok;
   logic arp_raw;
   logic arp_ok;
   logic all_ok;
   logic apb_wr;
   logic apb_rd_setup;
   logic [2:0] irq_ev;

   // Address decode for the error answer; the read mux has its own case
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      case (a)
         ADDR_W'(`AVM_OFF_CTRL), ADDR_W'(`AVM_OFF_ARP_CTRL), ADDR_W'(`AVM_OFF_SIP_ADDR),
         ADDR_W'(`AVM_OFF_SIP_MASK), ADDR_W'(`AVM_OFF_TIP_ADDR), ADDR_W'(`AVM_OFF_TIP_MASK),
         ADDR_W'(`AVM_OFF_HIT_COUNT), ADDR_W'(`AVM_OFF_IRQ_STATUS), ADDR_W'(`AVM_OFF_IRQ_CLEAR),
         ADDR_W'(`AVM_OFF_IRQ_ENABLE): mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   // ARP field checks
   avm_arp_check u_arp
   (
      .opk_mode(st.opk),
      .rr_mode(st.rr),
      .sip_mode(st.sipm),
      .tip_mode(st.tipm),
      .sha_mode(st.sha),
      .tha_mode(st.tha),
      .len_mode(st.len),
      .hrd_mode(st.hrd),
      .pro_mode(st.pro),
      .sip_addr(st.sip),
      .sip_mask(st.sipmsk),
      .tip_addr(st.tip),
      .tip_mask(st.tipmsk),
      .frame_source_mac(frame_source_mac),
      .arp_opcode(arp_opcode),
      .arp_sha(arp_sha),
      .arp_tha(arp_tha),
      .arp_spa(arp_spa),
      .arp_tpa(arp_tpa),
      .arp_hln(arp_hln),
      .arp_pln(arp_pln),
      .arp_hrd(arp_hrd),
      .arp_pro(arp_pro),
      .arp_ok(arp_raw)
   );

   // Per-criterion results for the presented frame
   assign type_ok = (st.ftype == FT_ANY) || (frm_kind == st.ftype);
   assign tag_ok = (st.tag == TAG_ONLY) ? frm_tagged : ((st.tag == TAG_NONE) ? !frm_tagged : 1'b1);
   assign vid_ok = !st.vid_spec || (frm_tagged && (frm_vid == st.vid));
   assign pcp_ok = !st.pcp_spec || (frm_tagged && (frm_pcp == st.pcp));
   assign arp_ok = (st.ftype != FT_ARP) || arp_raw;
   assign all_ok = type_ok && tag_ok && vid_ok && pcp_ok && arp_ok;

   // APB strobes; the slave never waits
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd_setup = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);

   // Next state: match result, counter, interrupts, registers
   always_comb
   begin
      next_st = st;
      next_st.res_valid = frm_valid;
      next_st.hit = frm_valid && all_ok;
      next_st.drop = frm_valid && all_ok && st.deny;
      irq_ev = 3'h0;
      if (frm_valid && all_ok)
      begin
         next_st.count = st.count + CNT_W'(1);
         irq_ev[`AVM_IRQ_HIT_BIT] = 1'b1;
         irq_ev[`AVM_IRQ_DROP_BIT] = st.deny;
         irq_ev[`AVM_IRQ_WRAP_BIT] = &st.count;
      end
      next_st.irq_st = st.irq_st | irq_ev;
      if (apb_wr)
      begin
         case (paddr)
            ADDR_W'(`AVM_OFF_CTRL):
            begin
               next_st.ftype = avm_ftype_t'(pwdata[`AVM_CTRL_TYPE_LSB +: 3]);
               next_st.deny = pwdata[`AVM_CTRL_DENY_BIT];
               next_st.tag = avm_tag_t'(pwdata[`AVM_CTRL_TAG_LSB +: 2]);
               next_st.vid_spec = pwdata[`AVM_CTRL_VIDSPEC_BIT];
               next_st.pcp_spec = pwdata[`AVM_CTRL_PCPSPEC_BIT];
               next_st.pcp = pwdata[`AVM_CTRL_PCP_LSB +: 3];
               next_st.vid = pwdata[`AVM_CTRL_VID_LSB +: 12];
            end
            ADDR_W'(`AVM_OFF_ARP_CTRL):
            begin
               next_st.opk = avm_opk_t'(pwdata[`AVM_ARP_OPK_LSB +: 2]);
               next_st.rr = avm_rr_t'(pwdata[`AVM_ARP_RR_LSB +: 2]);
               next_st.sipm = avm_ipm_t'(pwdata[`AVM_ARP_SIPM_LSB +: 2]);
               next_st.tipm = avm_ipm_t'(pwdata[`AVM_ARP_TIPM_LSB +: 2]);
               next_st.sha = avm_chk_t'(pwdata[`AVM_ARP_SHA_LSB +: 2]);
               next_st.tha = avm_chk_t'(pwdata[`AVM_ARP_THA_LSB +: 2]);
               next_st.len = avm_chk_t'(pwdata[`AVM_ARP_LEN_LSB +: 2]);
               next_st.hrd = avm_chk_t'(pwdata[`AVM_ARP_HRD_LSB +: 2]);
               next_st.pro = avm_chk_t'(pwdata[`AVM_ARP_PRO_LSB +: 2]);
            end
            ADDR_W'(`AVM_OFF_SIP_ADDR): next_st.sip = pwdata;
            ADDR_W'(`AVM_OFF_SIP_MASK): next_st.sipmsk = pwdata;
            ADDR_W'(`AVM_OFF_TIP_ADDR): next_st.tip = pwdata;
            ADDR_W'(`AVM_OFF_TIP_MASK): next_st.tipmsk = pwdata;
            // Clear loses to an event in the same cycle
            ADDR_W'(`AVM_OFF_IRQ_CLEAR): next_st.irq_st = (st.irq_st & ~pwdata[2:0]) | irq_ev;
            ADDR_W'(`AVM_OFF_IRQ_ENABLE): next_st.irq_en = pwdata[2:0];
            default: next_st.irq_en = st.irq_en;
         endcase
      end
      // Read data captured in the setup cycle
      if (apb_rd_setup)
      begin
         next_st.rdata = 32'h0000_0000;
         case (paddr)
            ADDR_W'(`AVM_OFF_CTRL):
            begin
               next_st.rdata[`AVM_CTRL_TYPE_LSB +: 3] = st.ftype;
               next_st.rdata[`AVM_CTRL_DENY_BIT] = st.deny;
               next_st.rdata[`AVM_CTRL_TAG_LSB +: 2] = st.tag;
               next_st.rdata[`AVM_CTRL_VIDSPEC_BIT] = st.vid_spec;
               next_st.rdata[`AVM_CTRL_PCPSPEC_BIT] = st.pcp_spec;
               next_st.rdata[`AVM_CTRL_PCP_LSB +: 3] = st.pcp;
               next_st.rdata[`AVM_CTRL_VID_LSB +: 12] = st.vid;
            end
            ADDR_W'(`AVM_OFF_ARP_CTRL):
            begin
               next_st.rdata[`AVM_ARP_OPK_LSB +: 2] = st.opk;
               next_st.rdata[`AVM_ARP_RR_LSB +: 2] = st.rr;
               next_st.rdata[`AVM_ARP_SIPM_LSB +: 2] = st.sipm;
               next_st.rdata[`AVM_ARP_TIPM_LSB +: 2] = st.tipm;
               next_st.rdata[`AVM_ARP_SHA_LSB +: 2] = st.sha;
               next_st.rdata[`AVM_ARP_THA_LSB +: 2] = st.tha;
               next_st.rdata[`AVM_ARP_LEN_LSB +: 2] = st.len;
               next_st.rdata[`AVM_ARP_HRD_LSB +: 2] = st.hrd;
               next_st.rdata[`AVM_ARP_PRO_LSB +: 2] = st.pro;
            end
            ADDR_W'(`AVM_OFF_SIP_ADDR): next_st.rdata = st.sip;
            ADDR_W'(`AVM_OFF_SIP_MASK): next_st.rdata = st.sipmsk;
            ADDR_W'(`AVM_OFF_TIP_ADDR): next_st.rdata = st.tip;
            ADDR_W'(`AVM_OFF_TIP_MASK): next_st.rdata = st.tipmsk;
            ADDR_W'(`AVM_OFF_HIT_COUNT): next_st.rdata = 32'(st.count);
            ADDR_W'(`AVM_OFF_IRQ_STATUS): next_st.rdata[2:0] = st.irq_st;
            ADDR_W'(`AVM_OFF_IRQ_ENABLE): next_st.rdata[2:0] = st.irq_en;
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register; reset gives all criteria don't-care
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs
   assign prdata = st.rdata;
   assign res_valid = st.res_valid;
   assign res_hit = st.hit;
   assign res_drop = st.drop;
   assign irq = |(st.irq_st & st.irq_en);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   tag_only_a: assert property (frm_valid && st.tag == TAG_ONLY && !frm_tagged |=> !res_hit)
      else $error("Untagged frame hit a tagged-only entry");
   untag_only_a: assert property (frm_valid && st.tag == TAG_NONE && frm_tagged |=> !res_hit)
      else $error("Tagged frame hit an untagged-only entry");
   vid_any_a: assert property (frm_valid && !st.vid_spec && type_ok && tag_ok && pcp_ok && arp_ok
                               |=> res_hit)
      else $error("VLAN ID affected match while don't-care");
   vid_spec_a: assert property (frm_valid && st.vid_spec && frm_vid != st.vid |=> !res_hit)
      else $error("Frame with other VLAN ID hit the entry");
   pcp_match_a: assert property (frm_valid && st.pcp_spec && frm_pcp != st.pcp |=> !res_hit)
      else $error("Frame with other priority hit the entry");
   arp_gate_a: assert property (frm_valid && st.ftype != FT_ARP && type_ok && tag_ok && vid_ok && pcp_ok
                                |=> res_hit)
      else $error("ARP criteria applied to a non-ARP entry");
   opk_arp_a: assert property (frm_valid && st.ftype == FT_ARP && st.opk == OPK_ARP
                               && arp_opcode != `AVM_OP_ARP_REQ && arp_opcode != `AVM_OP_ARP_REP
                               |=> !res_hit)
      else $error("Non-ARP opcode hit an ARP-opcode entry");
   rr_reply_a: assert property (frm_valid && st.ftype == FT_ARP && st.rr == RR_REPLY
                                && (arp_opcode == `AVM_OP_ARP_REQ || arp_opcode == `AVM_OP_RARP_REQ)
                                |=> !res_hit)
      else $error("Request opcode hit a reply entry");
   sip_host_a: assert property (frm_valid && st.ftype == FT_ARP && st.sipm == IPM_HOST && arp_spa != st.sip
                                |=> !res_hit)
      else $error("Sender IP mismatch hit a host entry");
   tip_net_a: assert property (frm_valid && st.ftype == FT_ARP && st.tipm == IPM_NET
                               && ((arp_tpa ^ st.tip) & st.tipmsk) != 32'h0000_0000 |=> !res_hit)
      else $error("Target IP outside network hit the entry");
   sha_eq_a: assert property (frm_valid && st.ftype == FT_ARP && st.sha == CHK_ONE && arp_sha != frame_source_mac
                              |=> !res_hit)
      else $error("Sender hardware address mismatch hit the entry");
   pro_ne_a: assert property (frm_valid && st.ftype == FT_ARP && st.pro == CHK_ZERO && arp_pro == `AVM_PRO_IP4
                              |=> !res_hit)
      else $error("IPv4 protocol type hit an inequality entry");
   deny_drop_a: assert property (res_valid |-> (res_drop == (res_hit && $past(st.deny))))
      else $error("Drop does not follow hit and deny");
   hit_count_a: assert property (res_hit |-> st.count == $past(st.count) + CNT_W'(1))
      else $error("Counter did not advance by one on hit");
   count_hold_a: assert property (!res_hit |-> $stable(st.count))
      else $error("Counter changed without a hit");
   all_ok_a: assert property (frm_valid |=> res_valid && (res_hit == $past(all_ok)))
      else $error("Hit does not equal combined criteria");
   irq_level_a: assert property (res_hit && st.irq_en[`AVM_IRQ_HIT_BIT] |-> irq)
      else $error("Enabled hit event did not raise interrupt");

   arp_hit_c: cover property (res_hit && st.ftype == FT_ARP && st.opk != OPK_ANY);
   drop_c: cover property (res_drop);
   vid_hit_c: cover property (res_hit && st.vid_spec && st.tag == TAG_ONLY);
   irq_c: cover property (irq ##1 !irq);

endmodule
`default_nettype wire

// >>> logic/avm_map.svh
`ifndef AVM_MAP_SVH
`define AVM_MAP_SVH

// Register byte offsets
`define AVM_OFF_CTRL 8'h00
`define AVM_OFF_ARP_CTRL 8'h04
`define AVM_OFF_SIP_ADDR 8'h08
`define AVM_OFF_SIP_MASK 8'h0c
`define AVM_OFF_TIP_ADDR 8'h10
`define AVM_OFF_TIP_MASK 8'h14
`define AVM_OFF_HIT_COUNT 8'h18
`define AVM_OFF_IRQ_STATUS 8'h1c
`define AVM_OFF_IRQ_CLEAR 8'h20
`define AVM_OFF_IRQ_ENABLE 8'h24

// Entry control field positions
`define AVM_CTRL_TYPE_LSB 0
`define AVM_CTRL_DENY_BIT 3
`define AVM_CTRL_TAG_LSB 4
`define AVM_CTRL_VIDSPEC_BIT 6
`define AVM_CTRL_PCPSPEC_BIT 7
`define AVM_CTRL_PCP_LSB 8
`define AVM_CTRL_VID_LSB 16

// ARP control field positions
`define AVM_ARP_OPK_LSB 0
`define AVM_ARP_RR_LSB 2
`define AVM_ARP_SIPM_LSB 4
`define AVM_ARP_TIPM_LSB 6
`define AVM_ARP_SHA_LSB 8
`define AVM_ARP_THA_LSB 10
`define AVM_ARP_LEN_LSB 12
`define AVM_ARP_HRD_LSB 14
`define AVM_ARP_PRO_LSB 16

// Reset values
`define AVM_RST_WORD 32'h0000_0000
`define AVM_RST_IRQ 3'h0

// Interrupt status bit positions
`define AVM_IRQ_HIT_BIT 0
`define AVM_IRQ_DROP_BIT 1
`define AVM_IRQ_WRAP_BIT 2

// ARP header reference values
`define AVM_HLN_ETH 8'h06
`define AVM_PLN_IP4 8'h04
`define AVM_HRD_ETH 16'h0001
`define AVM_PRO_IP4 16'h0800
`define AVM_OP_ARP_REQ 16'h0001
`define AVM_OP_ARP_REP 16'h0002
`define AVM_OP_RARP_REQ 16'h0003
`define AVM_OP_RARP_REP 16'h0004

`endif

// >>> logic/avm_pkg.sv
`default_nettype none
package avm_pkg;

   // Entry frame type, also the frame class from the parser
   typedef enum logic [2:0] {FT_ANY = 3'b000, FT_ETH = 3'b001, FT_ARP = 3'b010,
                             FT_IP4 = 3'b011, FT_IP6 = 3'b100} avm_ftype_t;
   typedef enum logic [1:0] {TAG_ANY = 2'b00, TAG_ONLY = 2'b01, TAG_NONE = 2'b10, TAG_ANY2 = 2'b11} avm_tag_t;
   typedef enum logic [1:0] {OPK_ANY = 2'b00, OPK_ARP = 2'b01, OPK_RARP = 2'b10, OPK_OTHER = 2'b11} avm_opk_t;
   typedef enum logic [1:0] {RR_ANY = 2'b00, RR_REQ = 2'b01, RR_REPLY = 2'b10, RR_ANY2 = 2'b11} avm_rr_t;
   typedef enum logic [1:0] {IPM_ANY = 2'b00, IPM_HOST = 2'b01, IPM_NET = 2'b10, IPM_ANY2 = 2'b11} avm_ipm_t;
   // Zero: fields must differ; one: fields must be equal
   typedef enum logic [1:0] {CHK_ANY = 2'b00, CHK_ZERO = 2'b01, CHK_ONE = 2'b10, CHK_ANY2 = 2'b11} avm_chk_t;

   // Three-way equality check
   function automatic logic chk_ok(input avm_chk_t m, input logic eq);
      case (m)
         CHK_ZERO: chk_ok = !eq;
         CHK_ONE: chk_ok = eq;
         default: chk_ok = 1'b1;
      endcase
   endfunction

   // Host or masked network address check
   function automatic logic ip_ok(input avm_ipm_t m, input logic [31:0] fld, input logic [31:0] adr,
                                  input logic [31:0] msk);
      case (m)
         IPM_HOST: ip_ok = (fld == adr);
         IPM_NET: ip_ok = (((fld ^ adr) & msk) == 32'h0000_0000);
         default: ip_ok = 1'b1;
      endcase
   endfunction

endpackage
`default_nettype wire

// >>> logic/avm_arp_check.sv
`timescale 1ns/100ps
`default_nettype none
`include "avm_map.svh"
module avm_arp_check
(
   input wire avm_pkg::avm_opk_t opk_mode,
   input wire avm_pkg::avm_rr_t rr_mode,
   input wire avm_pkg::avm_ipm_t sip_mode,
   input wire avm_pkg::avm_ipm_t tip_mode,
   input wire avm_pkg::avm_chk_t sha_mode,
   input wire avm_pkg::avm_chk_t tha_mode,
   input wire avm_pkg::avm_chk_t len_mode,
   input wire avm_pkg::avm_chk_t hrd_mode,
   input wire avm_pkg::avm_chk_t pro_mode,
   input wire logic [31:0] sip_addr,
   input wire logic [31:0] sip_mask,
   input wire logic [31:0] tip_addr,
   input wire logic [31:0] tip_mask,
   input wire logic [47:0] frame_source_mac,
   input wire logic [15:0] arp_opcode,
   input wire logic [47:0] arp_sha,
   input wire logic [47:0] arp_tha,
   input wire logic [31:0] arp_spa,
   input wire logic [31:0] arp_tpa,
   input wire logic [7:0] arp_hln,
   input wire logic [7:0] arp_pln,
   input wire logic [15:0] arp_hrd,
   input wire logic [15:0] arp_pro,
   output logic arp_ok
);
   import avm_pkg::*;

   logic is_arp_op;
   logic is_rarp_op;
   logic is_req;
   logic is_rep;
   logic opk_ok;
   logic rr_ok;

   // Opcode classes
   assign is_arp_op = (arp_opcode == `AVM_OP_ARP_REQ) || (arp_opcode == `AVM_OP_ARP_REP);
   assign is_rarp_op = (arp_opcode == `AVM_OP_RARP_REQ) || (arp_opcode == `AVM_OP_RARP_REP);
   assign is_req = (arp_opcode == `AVM_OP_ARP_REQ) || (arp_opcode == `AVM_OP_RARP_REQ);
   assign is_rep = (arp_opcode == `AVM_OP_ARP_REP) || (arp_opcode == `AVM_OP_RARP_REP);

   // Opcode kind and request or reply checks
   always_comb
   begin
      case (opk_mode)
         OPK_ARP: opk_ok = is_arp_op;
         OPK_RARP: opk_ok = is_rarp_op;
         OPK_OTHER: opk_ok = !is_arp_op && !is_rarp_op;
         default: opk_ok = 1'b1;
      endcase
      case (rr_mode)
         RR_REQ: rr_ok = is_req;
         RR_REPLY: rr_ok = is_rep;
         default: rr_ok = 1'b1;
      endcase
   end

   // All ARP criteria together
   assign arp_ok = opk_ok && rr_ok
                   && ip_ok(sip_mode, arp_spa, sip_addr, sip_mask)
                   && ip_ok(tip_mode, arp_tpa, tip_addr, tip_mask)
                   && chk_ok(sha_mode, arp_sha == frame_source_mac)
                   && chk_ok(tha_mode, arp_tha == frame_source_mac)
                   && chk_ok(len_mode, (arp_hln == `AVM_HLN_ETH) && (arp_pln == `AVM_PLN_IP4))
                   && chk_ok(hrd_mode, arp_hrd == `AVM_HRD_ETH)
                   && chk_ok(pro_mode, arp_pro == `AVM_PRO_IP4);

endmodule
`default_nettype wire

// >>> dv/avm_parser_model.sv
`timescale 1ns/100ps
`default_nettype none
module avm_parser_model
(
   input wire logic pclk,
   output var logic frm_valid,
   output var avm_pkg::avm_ftype_t frm_kind,
   output var logic frm_tagged,
   output var logic [11:0] frm_vid,
   output var logic [2:0] frm_pcp,
   output var logic [47:0] frame_source_mac,
   output var logic [15:0] arp_opcode,
   output var logic [47:0] arp_sha,
   output var logic [47:0] arp_tha,
   output var logic [31:0] arp_spa,
   output var logic [31:0] arp_tpa,
   output var logic [7:0] arp_hln,
   output var logic [7:0] arp_pln,
   output var logic [15:0] arp_hrd,
   output var logic [15:0] arp_pro
);
   import avm_pkg::*;
   // Bit i spoils one header field: sha, tha, hln, hrd, pro
   logic [4:0] spoil = 5'h00;
   // Idle fields at time zero
   initial
   begin
      frm_valid = 1'b0;
      frm_kind = FT_ANY;
      {frm_tagged, frm_vid, frm_pcp, frame_source_mac, arp_opcode, arp_sha, arp_tha} = '0;
      {arp_spa, arp_tpa, arp_hln, arp_pln, arp_hrd, arp_pro} = '0;
   end
   // One frame for one cycle, then fields turn to their inverse
   task automatic send(input avm_ftype_t k, input logic t, input logic [11:0] v, input logic [2:0] p,
                       input logic [15:0] op, input logic [31:0] spa, input logic [31:0] tpa);
      @(posedge pclk);
      frm_valid <= 1'b1;
      frm_kind <= k;
      {frm_tagged, frm_vid, frm_pcp, arp_opcode, arp_spa, arp_tpa} <= {t, v, p, op, spa, tpa};
      frame_source_mac <= 48'h0200_0000_0001;
      arp_sha <= spoil[0] ? 48'h0200_0000_0002 : 48'h0200_0000_0001;
      arp_tha <= spoil[1] ? 48'h0200_0000_0003 : 48'h0200_0000_0001;
      arp_hln <= spoil[2] ? 8'h08 : 8'h06;
      arp_pln <= 8'h04;
      arp_hrd <= spoil[3] ? 16'h0006 : 16'h0001;
      arp_pro <= spoil[4] ? 16'h86dd : 16'h0800;
      @(posedge pclk);
      frm_valid <= 1'b0;
      frm_kind <= avm_ftype_t'(~frm_kind);
      {frm_tagged, frm_vid, frm_pcp, arp_opcode, arp_spa, arp_tpa} <= ~{frm_tagged, frm_vid, frm_pcp,
                                                                       arp_opcode, arp_spa, arp_tpa};
      {frame_source_mac, arp_sha, arp_tha, arp_hln, arp_pln} <= ~{frame_source_mac, arp_sha, arp_tha,
                                                                 arp_hln, arp_pln};
      {arp_hrd, arp_pro} <= ~{arp_hrd, arp_pro};
   endtask
endmodule
`default_nettype wire

// >>> dv/test_avm_matcher.sv
`timescale 1ns/100ps
`default_nettype none
`include "avm_map.svh"
module test_avm_matcher;
   import avm_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_q;
   logic pready, pslverr, frm_valid, frm_tagged, res_valid, res_hit, res_drop, irq, rd_e;
   avm_ftype_t frm_kind;
   logic [11:0] frm_vid;
   logic [2:0] frm_pcp;
   logic [47:0] frame_source_mac, arp_sha, arp_tha;
   logic [15:0] arp_opcode, arp_hrd, arp_pro;
   logic [31:0] arp_spa, arp_tpa;
   logic [7:0] arp_hln, arp_pln;
   int err_total = 0, n_compared = 0, hits = 0;
   logic deny_on = 1'b0;
   avm_matcher avm_matcher_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid),
      .frm_kind(frm_kind), .frm_tagged(frm_tagged), .frm_vid(frm_vid), .frm_pcp(frm_pcp),
      .frame_source_mac(frame_source_mac), .arp_opcode(arp_opcode), .arp_sha(arp_sha), .arp_tha(arp_tha),
      .arp_spa(arp_spa), .arp_tpa(arp_tpa), .arp_hln(arp_hln), .arp_pln(arp_pln), .arp_hrd(arp_hrd),
      .arp_pro(arp_pro), .res_valid(res_valid), .res_hit(res_hit), .res_drop(res_drop), .irq(irq));
   avm_parser_model parser_i (.pclk(pclk), .frm_valid(frm_valid), .frm_kind(frm_kind), .frm_tagged(frm_tagged),
      .frm_vid(frm_vid), .frm_pcp(frm_pcp), .frame_source_mac(frame_source_mac), .arp_opcode(arp_opcode),
      .arp_sha(arp_sha), .arp_tha(arp_tha), .arp_spa(arp_spa), .arp_tpa(arp_tpa), .arp_hln(arp_hln),
      .arp_pln(arp_pln), .arp_hrd(arp_hrd), .arp_pro(arp_pro));
   // 10 MHz clock
   always #50 pclk = ~pclk;
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      n_compared++;
      if (g !== x)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, x);
      end
   endtask
   // APB transfer; answer left in rd_q and rd_e
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk(rd_q, x, "rdata");
      chk(rd_e, xe, "pslverr");
   endtask
   // One frame and its one-cycle result
   task automatic frm(input avm_ftype_t k, input logic t, input logic [11:0] v, input logic [2:0] p,
                      input logic [15:0] op, input logic [31:0] spa, input logic [31:0] tpa, input logic x);
      parser_i.send(k, t, v, p, op, spa, tpa);
      @(negedge pclk);
      chk(res_valid, 1, "valid");
      chk(res_hit, x, "hit");
      chk(res_drop, x & deny_on, "drop");
      hits += x;
   endtask
   task automatic fv(input logic t, input logic [11:0] v, input logic [2:0] p, input logic x);
      frm(FT_ETH, t, v, p, 16'h0, 32'h0, 32'h0, x);
   endtask
   task automatic fa(input logic [15:0] op, input logic [31:0] spa, input logic [31:0] tpa, input logic x);
      frm(FT_ARP, 1'b0, 12'h000, 3'h0, op, spa, tpa, x);
   endtask
   // Opcodes 1,2 ARP, 3,4 RARP; odd request, even reply
   function automatic logic op_exp(input int kd, input int rr, input int op);
      return (kd == 0 || kd == (op + 1) / 2) && (rr == 0 || rr == 3 || op < 5 && rr == 2 - op % 2);
   endfunction
   task automatic t_reset;
      rc(`AVM_OFF_CTRL, 32'h0, 1'b0);
      rc(`AVM_OFF_ARP_CTRL, 32'h0, 1'b0);
      rc(`AVM_OFF_HIT_COUNT, 32'h0, 1'b0);
      rc(8'h28, 32'h0, 1'b1);
      fv(1'b0, 12'h000, 3'h0, 1'b1);
   endtask
   task automatic t_vlan;
      wr(`AVM_OFF_CTRL, 32'h10);
      fv(1'b1, 12'h005, 3'h1, 1'b1);
      fv(1'b0, 12'h000, 3'h0, 1'b0);
      wr(`AVM_OFF_CTRL, 32'h20);
      fv(1'b1, 12'hffe, 3'h1, 1'b0);
      fv(1'b0, 12'h000, 3'h0, 1'b1);
      wr(`AVM_OFF_CTRL, 32'h30);
      fv(1'b1, 12'h005, 3'h1, 1'b1);
      wr(`AVM_OFF_CTRL, 32'hfff_0040);
      fv(1'b1, 12'hfff, 3'h0, 1'b1);
      fv(1'b1, 12'hffe, 3'h0, 1'b0);
      wr(`AVM_OFF_CTRL, 32'h780);
      fv(1'b1, 12'h003, 3'h7, 1'b1);
      fv(1'b1, 12'h003, 3'h6, 1'b0);
      wr(`AVM_OFF_CTRL, 32'h64_02c0);
      fv(1'b1, 12'h064, 3'h3, 1'b0);
      fv(1'b1, 12'h064, 3'h2, 1'b1);
   endtask
   task automatic t_arp;
      wr(`AVM_OFF_CTRL, 32'h0);
      wr(`AVM_OFF_ARP_CTRL, 32'h1);
      fv(1'b0, 12'h000, 3'h0, 1'b1);
      wr(`AVM_OFF_CTRL, 32'h2);
      fa(16'h0, 32'h0, 32'h0, 1'b0);
      // Every opcode kind against every request/reply setting
      for (int kd = 0; kd < 4; kd++)
         for (int rr = 0; rr < 4; rr++)
         begin
            wr(`AVM_OFF_ARP_CTRL, kd | rr << 2);
            for (int op = 1; op < 6; op++)
               fa(op[15:0], 32'h0, 32'h0, op_exp(kd, rr, op));
         end
   endtask
   task automatic t_ip;
      wr(`AVM_OFF_SIP_ADDR, 32'h0a00_0005);
      wr(`AVM_OFF_SIP_MASK, 32'hffff_ff00);
      wr(`AVM_OFF_TIP_ADDR, 32'hc0a8_0101);
      wr(`AVM_OFF_TIP_MASK, 32'hffff_0000);
      wr(`AVM_OFF_ARP_CTRL, 32'h10);
      fa(16'h1, 32'h0a00_0005, 32'h0, 1'b1);
      fa(16'h1, 32'h0a00_0007, 32'h0, 1'b0);
      wr(`AVM_OFF_ARP_CTRL, 32'h20);
      fa(16'h1, 32'h0a00_0007, 32'h0, 1'b1);
      fa(16'h1, 32'h0a01_0005, 32'h0, 1'b0);
      wr(`AVM_OFF_ARP_CTRL, 32'h40);
      fa(16'h1, 32'h0, 32'hc0a8_0101, 1'b1);
      fa(16'h1, 32'h0, 32'hc0a8_0102, 1'b0);
      wr(`AVM_OFF_ARP_CTRL, 32'h80);
      fa(16'h1, 32'h0, 32'hc0a8_ffff, 1'b1);
      fa(16'h1, 32'h0, 32'hc0a9_0101, 1'b0);
   endtask
   // Each header check in settings 1 to 3, with a sound and a spoiled frame
   task automatic t_hw;
      for (int i = 0; i < 5; i++)
         for (int m = 1; m < 4; m++)
         begin
            wr(`AVM_OFF_ARP_CTRL, m << (8 + 2 * i));
            parser_i.spoil = 5'h0;
            fa(16'h3, 32'h0, 32'h0, m != 1);
            parser_i.spoil = 5'h1 << i;
            fa(16'h3, 32'h0, 32'h0, m != 2);
         end
      parser_i.spoil = 5'h0;
   endtask
   task automatic t_irq;
      wr(`AVM_OFF_IRQ_CLEAR, 32'h7);
      wr(`AVM_OFF_CTRL, 32'h8);
      wr(`AVM_OFF_IRQ_ENABLE, 32'h7);
      rc(`AVM_OFF_IRQ_ENABLE, 32'h7, 1'b0);
      deny_on = 1'b1;
      fv(1'b0, 12'h000, 3'h0, 1'b1);
      chk(irq, 1, "irq on");
      rc(`AVM_OFF_IRQ_STATUS, 32'h3, 1'b0);
      wr(`AVM_OFF_IRQ_CLEAR, 32'h3);
      @(negedge pclk);
      chk(irq, 0, "irq off");
      wr(`AVM_OFF_IRQ_ENABLE, 32'h0);
      fv(1'b1, 12'h001, 3'h0, 1'b1);
      chk(irq, 0, "irq mask");
      rc(`AVM_OFF_IRQ_STATUS, 32'h3, 1'b0);
      rc(`AVM_OFF_HIT_COUNT, hits, 1'b0);
      wr(`AVM_OFF_HIT_COUNT, 32'h0);
      rc(`AVM_OFF_HIT_COUNT, hits, 1'b0);
      rc(`AVM_OFF_IRQ_CLEAR, 32'h0, 1'b0);
   endtask
   // Main sequence
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_vlan;
      t_arp;
      t_ip;
      t_hw;
      t_irq;
      report_and_stop;
   end
   // Watchdog
   initial
   begin
      #500000;
      err_total++;
      report_and_stop;
   end
endmodule
`default_nettype wire
